/* File: bench/astx_exec_assertions.sv */
module astx_exec_assertions #(
  parameter int DATA_W = 8,
  parameter int PROG_ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic opValid,
  input wire astx_pkg::astx_op_type opCode,
  input wire logic [DATA_W-1:0] immediate,
  input wire logic [2:0] bitSelect,
  input wire logic [DATA_W-1:0] memReadData,
  input wire logic [DATA_W-1:0] table_pointer_low,
  input wire logic opReady,
  input wire logic memWriteEn,
  input wire logic [DATA_W-1:0] memWriteData,
  input wire logic progReadEn,
  input wire logic [PROG_ADDR_W-1:0] progReadAddr,
  input wire logic skipNext,
  input wire logic dummyInsert,
  input wire logic [DATA_W-1:0] working_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  astx_pkg::astx_op_type c;
  logic bitVal;
  assign c = (opValid && opReady) ? opCode : astx_pkg::OP_NONE;
  assign bitVal = memReadData[bitSelect];
  property p_minus_to_memory;
    c == astx_pkg::OP_MINUS_TO_MEMORY |=> memWriteEn &&
      memWriteData == $past(working_register) - $past(memReadData);
  endproperty
  a_minus_to_memory: assert property (p_minus_to_memory) else $error("sub to memory");
  property p_subi;
    c == astx_pkg::OP_MINUS_IMMEDIATE |=>
      working_register == $past(working_register) - $past(immediate);
  endproperty
  a_subi: assert property (p_subi) else $error("sub immediate");
  property p_swap;
    c == astx_pkg::OP_NIBBLE_EXCHANGE |=> memWriteEn &&
      {memWriteData[3:0], memWriteData[7:4]} == $past(memReadData);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap");
  property p_sz;
    c == astx_pkg::OP_SKIP_ON_NULL |=> skipNext == ($past(memReadData) == 0);
  endproperty
  a_sz: assert property (p_sz) else $error("zero skip");
  property p_dummy;
    skipNext |-> !opReady ##1 (dummyInsert && opReady);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle");
  property p_bit;
    c == astx_pkg::OP_BIT_TEST_SKIP |=> skipNext == !$past(bitVal);
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip");
  property p_last;
    c == astx_pkg::OP_TABLE_READ_LAST_PAGE |=> progReadEn &&
      progReadAddr == {astx_pkg::LAST_PAGE, $past(table_pointer_low)};
  endproperty
  a_last: assert property (p_last) else $error("last page addr");
  property p_xori;
    c == astx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE |=>
      working_register == ($past(working_register) ^ $past(immediate));
  endproperty
  a_xori: assert property (p_xori) else $error("xor immediate");
endmodule

bind astx_exec astx_exec_assertions #(
  .DATA_W(DATA_W),
  .PROG_ADDR_W(PROG_ADDR_W)
) astx_exec_assertions_i (.core_clk, .resetn, .opValid, .opCode,
  .immediate, .bitSelect, .memReadData, .table_pointer_low, .opReady,
  .memWriteEn, .memWriteData, .progReadEn, .progReadAddr, .skipNext,
  .dummyInsert, .working_register);

/* File: bench/astx_prog_model.sv */
module astx_prog_model (
  input wire logic core_clk,
  input wire logic progReadEn,
  input wire logic [11:0] progReadAddr,
  output logic [15:0] progReadData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] junk_r = 16'h0000;
  always @(posedge core_clk) junk_r <= junk_r + 16'h9e37;
  // word answers in the enable cycle, a moving pattern otherwise
  assign progReadData = progReadEn ?
    {progReadAddr[7:0] ^ 8'h3c, 4'h0, progReadAddr[11:8]} : junk_r;
endmodule

/* File: bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic opValid = 1'h0;
  astx_pkg::astx_op_type opCode = astx_pkg::OP_NONE;
  logic [7:0] immediate = 8'h00, memReadData = 8'h00;
  logic [7:0] table_pointer_low = 8'h00, w = 8'h00;
  logic [3:0] currentPage = 4'h0, table_pointer_high = 4'h0;
  logic [2:0] bitSelect = 3'h0;
  logic carryIn = 1'h0, nullIn = 1'h0, halfIn = 1'h0, rangeIn = 1'h0;
  logic [15:0] progReadData;
  logic opReady, memWriteEn, progReadEn, skipNext, dummyInsert;
  logic borrow_out_flag, null_result_flag, half_borrow_flag;
  logic signed_range_flag;
  logic [7:0] memWriteData, working_register, table_high_byte_latch;
  logic [11:0] progReadAddr;
  int n_fail = 0, checked = 0;
  always #12.5 core_clk = ~core_clk;
  astx_exec astx_exec_i (.core_clk, .resetn, .opValid, .opCode, .immediate,
    .bitSelect, .memReadData, .currentPage, .table_pointer_low,
    .table_pointer_high, .progReadData, .carryIn, .nullIn, .halfIn,
    .rangeIn, .opReady, .memWriteEn, .memWriteData, .progReadEn,
    .progReadAddr, .skipNext, .dummyInsert, .working_register,
    .table_high_byte_latch, .borrow_out_flag, .null_result_flag,
    .half_borrow_flag, .signed_range_flag);
  astx_prog_model astx_prog_model_i (.core_clk, .progReadEn, .progReadAddr,
    .progReadData);
  task automatic test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // borrow, null, half borrow, signed range
  function automatic logic [3:0] subf(input logic [7:0] a, b);
    logic [7:0] d;
    d = a - b;
    return {a >= b, d == 8'h00, a[3:0] >= b[3:0],
      a[7] != b[7] && d[7] != a[7]};
  endfunction
  task automatic run(input astx_pkg::astx_op_type c, input logic [7:0] m);
    logic [7:0] r, im, tp;
    logic [3:0] fl, fi, pg, hp;
    logic [2:0] bs;
    logic [11:0] a;
    logic sk, mw, tr;
    {im, tp, fi, pg, hp, bs} = 31'($urandom);
    {fl, sk, mw, tr, a, r} = {fi, 3'h0, 12'h000, m};
    case (c)
      astx_pkg::OP_MINUS_TO_MEMORY: {r, fl, mw} = {w - m, subf(w, m), 1'h1};
      astx_pkg::OP_MINUS_IMMEDIATE: {w, fl} = {w - im, subf(w, im)};
      astx_pkg::OP_NIBBLE_EXCHANGE: {r, mw} = {m[3:0], m[7:4], 1'h1};
      astx_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: w = {m[3:0], m[7:4]};
      astx_pkg::OP_SKIP_ON_NULL: sk = m == 8'h00;
      astx_pkg::OP_NULL_TEST_COPY_SKIP: {w, sk} = {m, m == 8'h00};
      astx_pkg::OP_BIT_TEST_SKIP: sk = !m[bs];
      astx_pkg::OP_TABLE_READ_POINTER_PAGE: {tr, a} = {1'h1, hp, tp};
      astx_pkg::OP_TABLE_READ_CURRENT_PAGE: {tr, a} = {1'h1, pg, tp};
      astx_pkg::OP_TABLE_READ_LAST_PAGE: {tr, a} = {1'h1, 4'hf, tp};
      astx_pkg::OP_EXCLUSIVE_OR_FROM_MEMORY: {w, fl[2]} = {w ^ m, w == m};
      astx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY:
        {r, fl[2], mw} = {w ^ m, w == m, 1'h1};
      astx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: {w, fl[2]} = {w ^ im, w == im};
      default: ;
    endcase
    @(posedge core_clk);
    opCode <= c;
    {opValid, memReadData, immediate} <= {1'h1, m, im};
    {bitSelect, carryIn, nullIn, halfIn, rangeIn} <= {bs, fi};
    {currentPage, table_pointer_high, table_pointer_low} <= {pg, hp, tp};
    @(posedge core_clk);
    // an xor offered while stalled must be ignored
    opValid <= sk || tr;
    opCode <= astx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE;
    immediate <= 8'hff;
    #1;
    chk("memWriteEn", mw, memWriteEn);
    if (mw) chk("memWriteData", r, memWriteData);
    chk("skipNext", sk, skipNext);
    chk("working", w,
      working_register);
    chk("flags", fl, {borrow_out_flag, null_result_flag, half_borrow_flag,
      signed_range_flag});
    chk("progReadEn", tr, progReadEn);
    if (tr) chk("progReadAddr", a, progReadAddr);
    chk("opReady", !(sk || tr), opReady);
    @(posedge core_clk);
    opValid <= 1'h0;
    #1;
    chk("dummyInsert", sk, dummyInsert);
    chk("refused", w, working_register);
    chk("tableWrite", tr, memWriteEn);
    if (tr) chk("table", {a[7:0] ^ 8'h3c, 4'h0, a[11:8]},
      {table_high_byte_latch, memWriteData});
  endtask
  initial begin
    void'($urandom(62));
    repeat (6) @(posedge core_clk);
    chk("reset", 16'h0000, {working_register, table_high_byte_latch});
    resetn <= 1'h1;
    for (int i = 0; i < 300; i++) begin
      if (i < 42) run(astx_pkg::astx_op_type'(i % 14),
        i < 14 ? 8'h00 : (i < 28 ? 8'h80 : w));
      else run(astx_pkg::astx_op_type'($urandom_range(13)), 8'($urandom));
    end
    test_done();
  end
  initial begin
    #100us;
    n_fail++;
    test_done();
  end
endmodule

/* File: design/astx_exec.sv */
// Overview of operation
// [RULE1] minus-to-memory writes working minus memory back, updates four flags
// [RULE2] borrow-out is 0 on negative result, 1 on positive or zero
// [RULE3] immediate subtract into working register, updates four flags
// [RULE4] nibble exchange swaps memory byte halves in place, flags kept
// [RULE5] nibble exchange to working writes swapped byte, memory unchanged
// [RULE6] skip next instruction when memory byte is zero, flags kept
// [RULE7] every taken skip costs two cycles via a dummy instruction
// [RULE8] copy memory byte to working, skip when zero, flags kept
// [RULE9] skip next instruction when selected memory bit is zero
// [RULE10] pointer-page table read: word low to memory, high to latch
// [RULE11] current-page table read uses current page and low pointer
// [RULE12] last-page table read uses last page and low pointer
// [RULE13] xor memory into working register, only null flag changes
// [RULE14] xor written back to memory, only null flag changes
// [RULE15] xor immediate into working register, only null flag changes
// [RULE16] null flag set when whole written result is zero
module astx_exec #(
  parameter int DATA_W = astx_pkg::DATA_W,
  parameter int PROG_ADDR_W = astx_pkg::PROG_ADDR_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic opValid,
  input wire astx_pkg::astx_op_type opCode,
  input wire logic [DATA_W-1:0] immediate,
  input wire logic [2:0] bitSelect,
  input wire logic [DATA_W-1:0] memReadData,
  input wire logic [PROG_ADDR_W-DATA_W-1:0] currentPage,
  input wire logic [DATA_W-1:0] table_pointer_low,
  input wire logic [PROG_ADDR_W-DATA_W-1:0] table_pointer_high,
  input wire logic [astx_pkg::PROG_WORD_W-1:0] progReadData,
  input wire logic carryIn,
  input wire logic nullIn,
  input wire logic halfIn,
  input wire logic rangeIn,
  output logic opReady,
  output logic memWriteEn,
  output logic [DATA_W-1:0] memWriteData,
  output logic progReadEn,
  output logic [PROG_ADDR_W-1:0] progReadAddr,
  output logic skipNext,
  output logic dummyInsert,
  output logic [DATA_W-1:0] working_register,
  output logic [DATA_W-1:0] table_high_byte_latch,
  output logic borrow_out_flag,
  output logic null_result_flag,
  output logic half_borrow_flag,
  output logic signed_range_flag
);

  initial begin
    if (DATA_W != astx_pkg::DATA_W ||
        PROG_ADDR_W != astx_pkg::PROG_ADDR_W) begin
      $error("unsupported widths");
    end
  end

  typedef struct packed {
    astx_pkg::astx_state_type state;
    logic [DATA_W-1:0] work;
    logic [DATA_W-1:0] latch;
    logic memWe;
    logic [DATA_W-1:0] memWd;
    logic progRe;
    logic [PROG_ADDR_W-1:0] progAddr;
    logic skip;
    logic dummy;
    logic carry;
    logic zero;
    logic half;
    logic range;
  } astx_st_type;

  astx_st_type state_r;
  astx_st_type state_nxt;

  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] subRhs;
  logic subRange;
  logic subHalf;
  logic subBorrow;

  function automatic logic isNull(input logic [DATA_W-1:0] value);
    isNull = (value == '0);
  endfunction

  function automatic logic [DATA_W-1:0] swapNib(
    input logic [DATA_W-1:0] value
  );
    swapNib = {value[3:0], value[7:4]};
  endfunction

  assign subRhs = (opCode == astx_pkg::OP_MINUS_IMMEDIATE) ?
                  immediate : memReadData;

  astx_flag_unit #(
    .WIDTH(DATA_W)
  ) u_flag (
    .minuend(state_r.work),
    .subtrahend(subRhs),
    .difference(diff),
    .signedRange(subRange),
    .halfBorrow(subHalf),
    .borrowOut(subBorrow)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.memWe = 1'b0;
    state_nxt.progRe = 1'b0;
    state_nxt.skip = 1'b0;
    state_nxt.dummy = 1'b0;
    // flags follow the core's status until an operation changes them
    state_nxt.carry = carryIn;
    state_nxt.zero = nullIn;
    state_nxt.half = halfIn;
    state_nxt.range = rangeIn;
    case (state_r.state)
      astx_pkg::ST_RUN: begin
        if (opValid) begin
          case (opCode)
            // [RULE1] subtract into memory
            astx_pkg::OP_MINUS_TO_MEMORY: begin
              state_nxt.memWe = 1'b1;
              state_nxt.memWd = diff;
              state_nxt.carry = subBorrow;
              state_nxt.half = subHalf;
              state_nxt.range = subRange;
              state_nxt.zero = isNull(diff);
            end
            // [RULE3] subtract immediate
            astx_pkg::OP_MINUS_IMMEDIATE: begin
              state_nxt.work = diff;
              state_nxt.carry = subBorrow;
              state_nxt.half = subHalf;
              state_nxt.range = subRange;
              state_nxt.zero = isNull(diff);
            end
            // [RULE4] swap in place
            astx_pkg::OP_NIBBLE_EXCHANGE: begin
              state_nxt.memWe = 1'b1;
              state_nxt.memWd = swapNib(memReadData);
            end
            // [RULE5] swap to working
            astx_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: begin
              state_nxt.work = swapNib(memReadData);
            end
            // [RULE6] [RULE7] zero skip
            astx_pkg::OP_SKIP_ON_NULL: begin
              if (isNull(memReadData)) begin
                state_nxt.skip = 1'b1;
                state_nxt.state = astx_pkg::ST_SKIP_DUMMY;
              end
            end
            // [RULE8] copy then skip
            astx_pkg::OP_NULL_TEST_COPY_SKIP: begin
              state_nxt.work = memReadData;
              if (isNull(memReadData)) begin
                state_nxt.skip = 1'b1;
                state_nxt.state = astx_pkg::ST_SKIP_DUMMY;
              end
            end
            // [RULE9] bit test skip
            astx_pkg::OP_BIT_TEST_SKIP: begin
              if (!memReadData[bitSelect]) begin
                state_nxt.skip = 1'b1;
                state_nxt.state = astx_pkg::ST_SKIP_DUMMY;
              end
            end
            // [RULE10] pointer page address
            astx_pkg::OP_TABLE_READ_POINTER_PAGE: begin
              state_nxt.progRe = 1'b1;
              state_nxt.progAddr = {table_pointer_high, table_pointer_low};
              state_nxt.state = astx_pkg::ST_TABLE_WAIT;
            end
            // [RULE11] current page address
            astx_pkg::OP_TABLE_READ_CURRENT_PAGE: begin
              state_nxt.progRe = 1'b1;
              state_nxt.progAddr = {currentPage, table_pointer_low};
              state_nxt.state = astx_pkg::ST_TABLE_WAIT;
            end
            // [RULE12] last page address
            astx_pkg::OP_TABLE_READ_LAST_PAGE: begin
              state_nxt.progRe = 1'b1;
              state_nxt.progAddr = {astx_pkg::LAST_PAGE, table_pointer_low};
              state_nxt.state = astx_pkg::ST_TABLE_WAIT;
            end
            // [RULE13] [RULE16] xor to working
            astx_pkg::OP_EXCLUSIVE_OR_FROM_MEMORY: begin
              state_nxt.work = state_r.work ^ memReadData;
              state_nxt.zero = isNull(state_r.work ^ memReadData);
            end
            // [RULE14] [RULE16] xor to memory
            astx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
              state_nxt.memWe = 1'b1;
              state_nxt.memWd = state_r.work ^ memReadData;
              state_nxt.zero = isNull(state_r.work ^ memReadData);
            end
            // [RULE15] [RULE16] xor immediate
            astx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: begin
              state_nxt.work = state_r.work ^ immediate;
              state_nxt.zero = isNull(state_r.work ^ immediate);
            end
            default: begin
            end
          endcase
        end
      end
      // [RULE7] dummy cycle replaces fetched instruction
      astx_pkg::ST_SKIP_DUMMY: begin
        state_nxt.dummy = 1'b1;
        state_nxt.state = astx_pkg::ST_RUN;
      end
      // [RULE10] low byte to memory, high byte to latch
      astx_pkg::ST_TABLE_WAIT: begin
        state_nxt.memWe = 1'b1;
        state_nxt.memWd = progReadData[DATA_W-1:0];
        state_nxt.latch = progReadData[2*DATA_W-1:DATA_W];
        state_nxt.state = astx_pkg::ST_RUN;
      end
      default: begin
        state_nxt.state = astx_pkg::ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '{
        state: astx_pkg::ST_RUN,
        work: astx_pkg::WORKING_RESET,
        latch: astx_pkg::LATCH_RESET,
        default: '0
      };
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign opReady = (state_r.state == astx_pkg::ST_RUN);
  assign memWriteEn = state_r.memWe;
  assign memWriteData = state_r.memWd;
  assign progReadEn = state_r.progRe;
  assign progReadAddr = state_r.progAddr;
  assign skipNext = state_r.skip;
  assign dummyInsert = state_r.dummy;
  assign working_register = state_r.work;
  assign table_high_byte_latch = state_r.latch;
  assign borrow_out_flag = state_r.carry;
  assign null_result_flag = state_r.zero;
  assign half_borrow_flag = state_r.half;
  assign signed_range_flag = state_r.range;

endmodule

/* File: design/astx_flag_unit.sv */
module astx_flag_unit #(
  parameter int WIDTH = astx_pkg::DATA_W
) (
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  output logic [WIDTH-1:0] difference,
  output logic signedRange,
  output logic halfBorrow,
  output logic borrowOut
);

  initial begin
    if (WIDTH < 8) begin
      $error("width below 8 not served");
    end
  end

  logic [WIDTH:0] fullDiff;
  logic [4:0] lowDiff;

  // ----------------------------------------------------------------
  // subtraction and its flags
  // ----------------------------------------------------------------
  always_comb begin
    fullDiff = {1'b0, minuend} - {1'b0, subtrahend};
    lowDiff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    difference = fullDiff[WIDTH-1:0];
    // [RULE2] borrow-out polarity
    borrowOut = ~fullDiff[WIDTH];
    halfBorrow = ~lowDiff[4];
    signedRange = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
                & (minuend[WIDTH-1] ^ fullDiff[WIDTH-1]);
  end

endmodule

/* File: include/astx_pkg.sv */
package astx_pkg;

  // ----------------------------------------------------------------
  // operation codes presented by the decode stage
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_MINUS_TO_MEMORY,
    OP_MINUS_IMMEDIATE,
    OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_TO_WORKING,
    OP_SKIP_ON_NULL,
    OP_NULL_TEST_COPY_SKIP,
    OP_BIT_TEST_SKIP,
    OP_TABLE_READ_POINTER_PAGE,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_EXCLUSIVE_OR_FROM_MEMORY,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_EXCLUSIVE_OR_IMMEDIATE
  } astx_op_type;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PROG_ADDR_W = 12;
  localparam int PROG_WORD_W = 16;
  localparam int PAGE_SEL_W = PROG_ADDR_W - DATA_W;
  localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [PAGE_SEL_W-1:0] LAST_PAGE = 4'hf;

  // ----------------------------------------------------------------
  // execution states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SKIP_DUMMY,
    ST_TABLE_WAIT
  } astx_state_type;

endpackage
